// ==== inc/timer0_cfg.svh ====
`ifndef TIMER0_CFG_SVH
`define TIMER0_CFG_SVH

// ****************************************************************
// Register addresses and reset values
// ****************************************************************
`define TMR_ADDR 5'h01
`define OPTION_RESET 8'hff
`define TRIS_RESET 4'hf
`define EXT_PIN_TRIS_BIT 2

// ****************************************************************
// Configuration field positions
// ****************************************************************
`define OPT_PIN_WAKE_BIT 7
`define OPT_PULLUP_BIT 6
`define OPT_CLK_SRC_BIT 5
`define OPT_EDGE_SEL_BIT 4
`define OPT_ASSIGN_BIT 3
`define OPT_RATE_MSB 2
`define OPT_RATE_LSB 0

// ****************************************************************
// Timing counts
// ****************************************************************
`define WRITE_INHIBIT_CYCLES 2'd2
`define PSC_RESET 8'h00
`define TMR_RESET 8'h00

`endif

// ==== inc/timer0_pkg.sv ====
package timer0_pkg;

  // ****************************************************************
  // Internal phase clocks of one instruction cycle
  // ****************************************************************
  typedef enum logic [1:0] {
    PHASE_ONE = 2'b00,
    PHASE_TWO = 2'b01,
    PHASE_THREE = 2'b10,
    PHASE_FOUR = 2'b11
  } phase_t;

  // ****************************************************************
  // Timer and wake configuration register layout
  // ****************************************************************
  typedef struct packed {
    logic pinWakeDisable;
    logic pullupDisable;
    logic clockSourceSelect;
    logic sourceEdgeSelect;
    logic prescalerAssign;
    logic [2:0] prescaleRate;
  } option_t;

endpackage

// ==== rtl/phase_gen.sv ====
`timescale 1ns/1ps
module phase_gen
  import timer0_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Phase state
  output phase_t phase_q
);

  // ****************************************************************
  // Four phase clocks per instruction cycle
  // ****************************************************************
  phase_t phase_d;

  // Next phase
  always_comb begin
    case (phase_q)
      PHASE_ONE: phase_d = PHASE_TWO;
      PHASE_TWO: phase_d = PHASE_THREE;
      PHASE_THREE: phase_d = PHASE_FOUR;
      PHASE_FOUR: phase_d = PHASE_ONE;
      default: phase_d = PHASE_ONE;
    endcase
  end

  // Phase register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_q <= PHASE_ONE;
    end else begin
      phase_q <= phase_d;
    end
  end

endmodule

// ==== rtl/timer0_prescaler.sv ====
`timescale 1ns/1ps
`include "timer0_cfg.svh"

// Summary of operation
// RULE1 - Source select clear: timer mode, one count per instruction cycle.
// RULE2 - A write to the count blocks incrementing for two cycles.
// RULE3 - Source select set: counter mode, count edges of the input pin.
// RULE4 - Edge select zero counts rising edges, one counts falling edges.
// RULE5 - Prescaler serves timer or watchdog, chosen by the assign bit.
// RULE6 - Timer prescale ratios run from 1:2 to 1:256 in powers of two.
// RULE7 - Rate field value n gives a timer ratio of two to n plus one.
// RULE8 - Prescaler count cannot be read or loaded by software.
// RULE9 - Any reset clears the prescaler to zero.
// RULE10 - Count writes clear the prescaler while it serves the timer.
// RULE11 - Watchdog clear clears the prescaler while it serves the watchdog.
// RULE12 - Counter mode forces the input pin to act as an input.
// RULE13 - Without prescaler the input passes straight to the output.
// RULE14 - Prescaler output is sampled on phases two and four.
// RULE15 - Prescaler divides the input so its output is symmetrical.
// RULE16 - Source holds input high and low two oscillator periods each.
// RULE17 - Prescaled input period at least four periods over the ratio.
// RULE18 - Count advances three to seven oscillator periods after an edge.
// RULE19 - Software clears watchdog then count before moving to watchdog.
// RULE20 - Software clears watchdog before moving prescaler to timer.
// RULE21 - Count register is eight bits, address 01h, read and write.
// RULE22 - Count wraps from ffh to 00h and keeps counting.
module timer0_prescaler
  import timer0_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Data register access
  input wire logic [4:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData_q,
  // Configuration and direction writes
  input wire logic optionWrEn,
  input wire option_t optionWrData,
  input wire logic trisWrEn,
  input wire logic [3:0] trisWrData,
  // Watchdog link
  input wire logic watchdogClearInstr,
  input wire logic watchdogTick,
  output logic watchdogTimeout_q,
  // Count input pin
  input wire logic extCountInput,
  input wire logic pinLatchData,
  output logic extPinOut_q,
  output logic extPinOe_q,
  // Status
  output logic [7:0] timerCount_q,
  output logic pinWakeDisable_q,
  output logic pullupDisable_q
);

  // ****************************************************************
  // Phase clocks
  // ****************************************************************
  phase_t phase;
  logic phaseTwo;
  logic phaseFour;

  phase_gen u_phase (
    .sys_clk(sys_clk),
    .rst(rst),
    .phase_q(phase)
  );

  // Sampling and instruction cycle end points
  assign phaseTwo = (phase == PHASE_TWO);
  assign phaseFour = (phase == PHASE_FOUR);

  // ****************************************************************
  // Configuration and direction registers
  // ****************************************************************
  option_t option_q;
  logic [3:0] pinDirection_q;
  logic clockSource;
  logic edgeSelect;
  logic toWatchdog;
  logic [2:0] rate;

  // Write-only configuration register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      option_q <= `OPTION_RESET;
    end else if (optionWrEn) begin
      option_q <= optionWrData;
    end
  end

  // Write-only pin direction register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinDirection_q <= `TRIS_RESET;
    end else if (trisWrEn) begin
      pinDirection_q <= trisWrData;
    end
  end

  // Field decode
  assign clockSource = option_q.clockSourceSelect;
  assign edgeSelect = option_q.sourceEdgeSelect;
  assign toWatchdog = option_q.prescalerAssign; // see RULE5
  assign rate = option_q.prescaleRate;

  // Configuration bits for the port logic
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinWakeDisable_q <= 1'b1;
      pullupDisable_q <= 1'b1;
    end else begin
      pinWakeDisable_q <= option_q.pinWakeDisable;
      pullupDisable_q <= option_q.pullupDisable;
    end
  end

  // ****************************************************************
  // Count input pin driver
  // ****************************************************************
  logic pinDirIn;

  assign pinDirIn = pinDirection_q[`EXT_PIN_TRIS_BIT];

  // Counter mode overrides the direction bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      extPinOe_q <= 1'b0;
      extPinOut_q <= 1'b0;
    end else begin
      extPinOe_q <= !pinDirIn && !clockSource; // see RULE12
      extPinOut_q <= pinLatchData;
    end
  end

  // ****************************************************************
  // Edge detect on the count input
  // ****************************************************************
  logic extPrev_q;
  logic extLevel;
  logic extEdge;

  // Falling edges become rising by inversion
  assign extLevel = extCountInput ^ edgeSelect; // see RULE4
  assign extEdge = extLevel && !extPrev_q;

  // Previous level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      extPrev_q <= 1'b0;
    end else begin
      extPrev_q <= extLevel;
    end
  end

  // ****************************************************************
  // Shared prescaler
  // ****************************************************************
  logic [7:0] pscCount_q;
  logic timerWrite;
  logic pscTimerStep;
  logic pscDogStep;
  logic [8:0] timerMask;
  logic [7:0] dogMask;
  logic pscTimerWrap;
  logic pscDogWrap;
  logic pscOutBit;

  assign timerWrite = regWrEn && (regAddr == `TMR_ADDR);

  // Ratio 2^(n+1) for the timer, 2^n for the watchdog
  assign timerMask = (9'h002 << rate) - 9'h001; // see RULE7
  assign dogMask = (8'h01 << rate) - 8'h01;
  assign pscTimerWrap =
    ((pscCount_q & timerMask[7:0]) == timerMask[7:0]); // see RULE6
  assign pscDogWrap = ((pscCount_q & dogMask) == dogMask);
  assign pscOutBit = pscCount_q[rate]; // see RULE15

  // Prescaler clock source depends on mode and assignment
  assign pscTimerStep = !toWatchdog &&
    (clockSource ? extEdge : phaseFour);
  assign pscDogStep = toWatchdog && watchdogTick;

  // Hidden counter, no software path in or out
  always_ff @(posedge sys_clk or posedge rst) begin // see RULE8
    if (rst) begin
      pscCount_q <= `PSC_RESET; // see RULE9
    end else if (timerWrite && !toWatchdog) begin
      pscCount_q <= `PSC_RESET; // see RULE10
    end else if (watchdogClearInstr && toWatchdog) begin
      pscCount_q <= `PSC_RESET; // see RULE11
    end else if (pscTimerStep || pscDogStep) begin
      pscCount_q <= pscCount_q + 8'h01;
    end
  end

  // Watchdog timeout, postscaled when assigned
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      watchdogTimeout_q <= 1'b0;
    end else if (toWatchdog) begin
      watchdogTimeout_q <= pscDogStep && pscDogWrap &&
        !watchdogClearInstr; // see RULE5
    end else begin
      watchdogTimeout_q <= watchdogTick;
    end
  end

  // ****************************************************************
  // Counter mode synchroniser
  // ****************************************************************
  logic pscOutLevel;
  logic sample_q;
  logic samplePrev_q;
  logic stepPend_q;
  logic counterStep;

  // Bypass divider when the prescaler is with the watchdog
  assign pscOutLevel = toWatchdog ? extLevel : pscOutBit; // see RULE13

  // Sample on phase two and phase four
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sample_q <= 1'b0;
    end else if (phaseTwo || phaseFour) begin
      sample_q <= pscOutLevel; // see RULE14
    end
  end

  // Rising edge of the sampled output
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      samplePrev_q <= 1'b0;
    end else begin
      samplePrev_q <= sample_q;
    end
  end

  // Extra stage so the step lands three or more clocks after the pin edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stepPend_q <= 1'b0;
    end else begin
      stepPend_q <= sample_q && !samplePrev_q; // see RULE18
    end
  end

  assign counterStep = clockSource && stepPend_q; // see RULE3 see RULE18

  // ****************************************************************
  // Write inhibit
  // ****************************************************************
  logic [1:0] inhibit_q;

  // Two instruction cycle ends are skipped after a write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inhibit_q <= 2'd0;
    end else if (timerWrite) begin
      inhibit_q <= `WRITE_INHIBIT_CYCLES; // see RULE2
    end else if (phaseFour && inhibit_q != 2'd0) begin
      inhibit_q <= inhibit_q - 2'd1;
    end
  end

  // ****************************************************************
  // Timer count register
  // ****************************************************************
  logic timerStep;
  logic modeStep;

  // Timer mode steps at each cycle end, via prescaler if assigned
  assign modeStep = clockSource ? counterStep :
    (phaseFour && (toWatchdog || pscTimerWrap)); // see RULE1
  assign timerStep = modeStep && (inhibit_q == 2'd0);

  // Load on write, otherwise free-running with wrap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timerCount_q <= `TMR_RESET;
    end else if (timerWrite) begin
      timerCount_q <= regWrData; // see RULE21
    end else if (timerStep) begin
      timerCount_q <= timerCount_q + 8'h01; // see RULE22
    end
  end

  // Read data for the count address
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData_q <= 8'h00;
    end else if (regRdEn && regAddr == `TMR_ADDR) begin
      regRdData_q <= timerCount_q; // see RULE21
    end else begin
      regRdData_q <= 8'h00;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking dcb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_timer_mode_step: assert property ( // see RULE1
    (!clockSource && toWatchdog && phaseFour && inhibit_q == 2'd0
      && !timerWrite && !optionWrEn)
    |=> timerCount_q == $past(timerCount_q) + 8'h01)
    else $error("timer mode count did not step");

  a_write_load: assert property ( // see RULE21
    timerWrite |=> timerCount_q == $past(regWrData))
    else $error("count write not loaded");

  a_inhibit_hold: assert property ( // see RULE2
    timerWrite ##1 (!timerWrite)[*8] |-> $stable(timerCount_q))
    else $error("count moved within two cycles of a write");

  a_psc_write_clear: assert property ( // see RULE10
    (timerWrite && !toWatchdog) |=> pscCount_q == 8'h00)
    else $error("prescaler not cleared by count write");

  a_psc_wdt_clear: assert property ( // see RULE11
    (watchdogClearInstr && toWatchdog && !timerWrite)
    |=> pscCount_q == 8'h00)
    else $error("prescaler not cleared by watchdog clear");

  a_psc_reset_zero: assert property ( // see RULE9
    @(posedge sys_clk) disable iff (1'b0)
    $fell(rst) |-> pscCount_q == 8'h00)
    else $error("prescaler not zero after reset");

  a_pin_input_force: assert property ( // see RULE12
    (clockSource && !optionWrEn) |=> !extPinOe_q)
    else $error("count pin driven in counter mode");

  a_sample_phases: assert property ( // see RULE14
    $changed(sample_q) |-> $past(phaseTwo || phaseFour))
    else $error("sample changed outside phases two and four");

  a_bypass_edge: assert property ( // see RULE13
    (clockSource && toWatchdog && !optionWrEn && !timerWrite
      && phaseTwo && extLevel && !sample_q && inhibit_q == 2'd0)
    |-> ##3 timerCount_q == $past(timerCount_q, 3) + 8'h01)
    else $error("bypassed edge did not step the count");

  a_ratio_two: assert property ( // see RULE6
    (!clockSource && !toWatchdog && rate == 3'd0 && phaseFour
      && pscCount_q[0] == 1'b0 && !timerWrite)
    |=> $stable(timerCount_q))
    else $error("prescaled timer stepped on even count");

  c_timer_wrap: cover property (
    timerStep && timerCount_q == 8'hff);
  c_counter_step: cover property (
    counterStep && !toWatchdog);
  c_dog_timeout: cover property (
    toWatchdog && watchdogTimeout_q);

endmodule

// ==== test/ext_pulse_src.sv ====
`timescale 1ns/1ps
module ext_pulse_src (
  // Clock
  input wire logic sys_clk,
  // Burst request
  input wire logic go,
  input wire logic [7:0] pulses,
  input wire logic [3:0] halfLen,
  // Pin side
  output logic pinLevel_q,
  output logic busy_q
);
  logic [7:0] left_q;
  logic [3:0] cnt_q;

  // Idle low with no burst pending
  initial begin
    pinLevel_q = 1'b0;
    busy_q = 1'b0;
  end

  // Whole pulses, each half held halfLen clocks (callers give 2 or more)
  always @(posedge sys_clk) begin
    if (go && !busy_q) begin
      busy_q <= 1'b1;
      left_q <= pulses;
      cnt_q <= 4'h1;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == halfLen) begin
        cnt_q <= 4'h1;
        pinLevel_q <= ~pinLevel_q;
        if (pinLevel_q) begin
          left_q <= left_q - 8'h01;
          busy_q <= (left_q != 8'h01);
        end
      end
    end
  end
endmodule

// ==== test/test_timer0_prescaler.sv ====
`timescale 1ns/1ps
module test_timer0_prescaler
  import timer0_pkg::*;
;
  logic sys_clk, rst, regWrEn, regRdEn, optionWrEn, trisWrEn;
  logic [4:0] regAddr;
  logic [7:0] regWrData, regRdData_q, timerCount_q, pulses;
  option_t optionWrData;
  logic [3:0] trisWrData, halfLen;
  logic watchdogClearInstr, watchdogTick, watchdogTimeout_q;
  logic extCountInput, pinLatchData, extPinOut_q, extPinOe_q;
  logic pinWakeDisable_q, pullupDisable_q, go, srcLevel_q, srcBusy_q;
  int mismatches = 0;
  int nChecks = 0;
  int nTimeouts = 0;
  int d;

  timer0_prescaler timer0_prescaler_i (.sys_clk(sys_clk), .rst(rst),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData_q(regRdData_q),
    .optionWrEn(optionWrEn), .optionWrData(optionWrData),
    .trisWrEn(trisWrEn), .trisWrData(trisWrData),
    .watchdogClearInstr(watchdogClearInstr), .watchdogTick(watchdogTick),
    .watchdogTimeout_q(watchdogTimeout_q), .extCountInput(extCountInput),
    .pinLatchData(pinLatchData), .extPinOut_q(extPinOut_q),
    .extPinOe_q(extPinOe_q), .timerCount_q(timerCount_q),
    .pinWakeDisable_q(pinWakeDisable_q), .pullupDisable_q(pullupDisable_q));

  ext_pulse_src ext_pulse_src_i (.sys_clk(sys_clk), .go(go),
    .pulses(pulses), .halfLen(halfLen), .pinLevel_q(srcLevel_q),
    .busy_q(srcBusy_q));

  // Pin level: device when it drives, else the pulse source
  assign extCountInput = extPinOe_q ? extPinOut_q : srcLevel_q;

  // Clock and timeout pulse counting
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (watchdogTimeout_q === 1'b1) nTimeouts++;

  task automatic finish_test();
    if (mismatches == 0 && nChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic clk1();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] exp, got);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // ****
  // Access tasks, entered just after an edge
  // ****
  task automatic doReset();
    rst = 1'b1;
    repeat (4) clk1();
    rst = 1'b0;
  endtask

  task automatic writeOption(input logic [7:0] v);
    optionWrEn = 1'b1;
    optionWrData = v;
    clk1();
    optionWrEn = 1'b0;
  endtask

  task automatic writeCount(input logic [7:0] v);
    regWrEn = 1'b1;
    regAddr = 5'h01;
    regWrData = v;
    clk1();
    regWrEn = 1'b0;
  endtask

  task automatic readReg(input logic [4:0] a, input logic [7:0] exp);
    regRdEn = 1'b1;
    regAddr = a;
    clk1();
    regRdEn = 1'b0;
    check("readData", exp, regRdData_q);
    clk1();
  endtask

  task automatic clearWatchdog();
    watchdogClearInstr = 1'b1;
    clk1();
    watchdogClearInstr = 1'b0;
  endtask

  task automatic ticks(input int n, input int exp);
    repeat (n) begin
      watchdogTick = 1'b1;
      clk1();
      watchdogTick = 1'b0;
      clk1();
    end
    repeat (2) clk1();
    check("timeouts", 8'(exp), 8'(nTimeouts));
  endtask

  task automatic waitStep(output int n);
    logic [7:0] was;
    was = timerCount_q;
    n = 0;
    while (timerCount_q === was && n < 3000) begin
      clk1();
      n++;
    end
  endtask

  task automatic startBurst(input logic [7:0] p, input logic [3:0] h);
    go = 1'b1;
    pulses = p;
    halfLen = h;
    clk1();
    go = 1'b0;
  endtask

  task automatic settleCount();
    repeat (4) clk1();
    writeCount(8'h00);
    repeat (12) clk1();
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    {regWrEn, regRdEn, optionWrEn, trisWrEn, go} = 5'h00;
    {regAddr, regWrData, optionWrData, trisWrData} = 25'h0;
    {watchdogClearInstr, watchdogTick, pinLatchData} = 3'h0;
    {pulses, halfLen} = 12'h0;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    check("resetCount", 8'h00, timerCount_q);
    check("resetPins", 8'h06,
      {5'h0, pinWakeDisable_q, pullupDisable_q, extPinOe_q});
    ticks(100, 0);
    doReset();
    ticks(127, 0);
    ticks(1, 1);
    writeOption(8'hca);
    ticks(3, 1);
    clearWatchdog();
    ticks(3, 1);
    ticks(1, 2);
    writeCount(8'hfd);
    waitStep(d);
    check("inhibit", 8'h01, 8'(d > 4 && d <= 12));
    check("count", 8'hfe, timerCount_q);
    waitStep(d);
    check("stepGap", 8'h01, 8'(d == 4));
    waitStep(d);
    check("wrap", 8'h00, timerCount_q);
    clearWatchdog();
    for (int n = 0; n < 8; n++) begin
      writeOption(8'hc0 | 8'(n));
      writeCount(8'h00);
      waitStep(d);
      waitStep(d);
      check("ratioGap", 8'h01, 8'(d == (8 << n)));
      check("count", 8'h02, timerCount_q);
    end
    repeat (600) clk1();
    writeCount(8'h40);
    waitStep(d);
    check("pscClear", 8'h01, 8'(d > 900));
    ticks(2, 4);
    trisWrEn = 1'b1;
    pinLatchData = 1'b1;
    clk1();
    trisWrEn = 1'b0;
    repeat (2) clk1();
    check("pinDrive", 8'h03, {6'h0, extPinOe_q, extPinOut_q});
    clearWatchdog();
    writeCount(8'h00);
    for (int e = 0; e < 2; e++) begin
      writeOption(e == 1 ? 8'hf8 : 8'he8);
      settleCount();
      check("pinOe", 8'h00, {7'h0, extPinOe_q});
      startBurst(8'h01, 4'h8);
      for (int i = 0; i < 20 && srcLevel_q !== 1'b1; i++) clk1();
      if (e == 1) for (int i = 0; i < 20 && srcLevel_q !== 1'b0; i++) clk1();
      waitStep(d);
      check("edgeDelay", 8'h01, 8'(d >= 3 && d <= 7));
      for (int i = 0; i < 40 && srcBusy_q; i++) clk1();
      startBurst(8'h05, 4'h2);
      repeat (40) clk1();
      readReg(5'h01, 8'h06);
    end
    clearWatchdog();
    writeOption(8'he1);
    settleCount();
    startBurst(8'h08, 4'h2);
    repeat (60) clk1();
    readReg(5'h01, 8'h02);
    readReg(5'h02, 8'h00);
    finish_test();
  end

  // Hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    finish_test();
  end
endmodule
